// >>> shared/cycle_timing_pkg.sv
// constants and types shared by the instruction cycle timing block
// Overview of operation
// - machine cycle is four ordered phase states
// - sequencing uses both clock edges
// - one opcode byte fetched in each of the first byte_count machine cycles
// - all 256 opcodes decode; 128 single-cycle
// - external data move lasts two to nine cycles
// - strobe widens with added machine cycles
// - other instructions take one to four cycles
// - compare jump forms: three bytes, sixteen clocks
// - stretch field sets move length two plus value
// - stretch affects only external data move
package cycle_timing_pkg;

    typedef enum logic [3:0] {
        phase_one = 4'h1,
        phase_two = 4'h2,
        phase_three = 4'h4,
        phase_four = 4'h8
    } phase_t;

    localparam int CLK_PERIOD_NS = 10;
    localparam int CLOCKS_PER_MCYCLE = 4;
    localparam logic [2:0] STRETCH_RST = 3'h1;
    localparam logic [3:0] XMOVE_BASE_CYCLES = 4'h2;
    localparam logic [7:0] OPCODE_RST = 8'h00;
    localparam logic [7:0] COMPARE_JUMP_NOT_EQUAL_FIRST = 8'hB4;
    localparam logic [7:0] COMPARE_JUMP_NOT_EQUAL_LAST = 8'hBF;
    localparam logic [1:0] COMPARE_JUMP_NOT_EQUAL_BYTES = 2'h3;
    localparam logic [5:0] COMPARE_JUMP_NOT_EQUAL_CLOCKS = 6'h10;
    localparam logic [3:0] MCYCLE_RST = 4'h0;
    localparam logic [5:0] COUNT_RST = 6'h00;

endpackage : cycle_timing_pkg

// >>> rtl/opcode_length_decoder.sv
// opcode decoder giving byte count, base machine cycles and move kind
`timescale 1ns/1ns
`default_nettype none
module opcode_length_decoder
    import cycle_timing_pkg::*;
(
    input wire logic [7:0] opcode,
    output logic [1:0] byte_count,
    output logic [2:0] base_cycles,
    output logic is_xmove,
    output logic is_write
);

    wire [3:0] hi = opcode[7:4];
    wire [3:0] lo = opcode[3:0];

    always_comb begin
        byte_count = 2'h1;
        base_cycles = 3'h1;
        is_xmove = 1'b0;
        is_write = opcode[4];
        case (lo)
            4'h0: begin
                case (hi)
                    4'h0: ;
                    4'h1, 4'h2, 4'h3: begin
                        byte_count = 2'h3;
                        base_cycles = 3'h4;
                    end
                    4'h4, 4'h5, 4'h6, 4'h7, 4'h8: begin
                        byte_count = 2'h2;
                        base_cycles = 3'h3;
                    end
                    4'h9: begin
                        byte_count = 2'h3;
                        base_cycles = 3'h3;
                    end
                    4'hE, 4'hF: is_xmove = 1'b1;
                    default: begin
                        byte_count = 2'h2;
                        base_cycles = 3'h2;
                    end
                endcase
            end
            4'h1: begin
                byte_count = 2'h2;
                base_cycles = 3'h3;
            end
            4'h2: begin
                case (hi)
                    4'h0, 4'h1: begin
                        byte_count = 2'h3;
                        base_cycles = 3'h4;
                    end
                    4'h2, 4'h3: base_cycles = 3'h2;
                    4'hE, 4'hF: is_xmove = 1'b1;
                    default: begin
                        byte_count = 2'h2;
                        base_cycles = 3'h2;
                    end
                endcase
            end
            4'h3: begin
                case (hi)
                    4'h4, 4'h5, 4'h6: begin
                        byte_count = 2'h3;
                        base_cycles = 3'h3;
                    end
                    4'h7, 4'h8, 4'h9, 4'hA: base_cycles = 3'h2;
                    4'hE, 4'hF: is_xmove = 1'b1;
                    default: ;
                endcase
            end
            4'h4: begin
                case (hi)
                    4'h0, 4'h1, 4'h8, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF: ;
                    4'hB: begin
                        byte_count = 2'h3;
                        base_cycles = 3'h4;
                    end
                    default: begin
                        byte_count = 2'h2;
                        base_cycles = 3'h2;
                    end
                endcase
            end
            4'h5: begin
                byte_count = 2'h2;
                base_cycles = 3'h2;
                case (hi)
                    4'h7, 4'h8: begin
                        byte_count = 2'h3;
                        base_cycles = 3'h3;
                    end
                    4'hB, 4'hD: begin
                        byte_count = 2'h3;
                        base_cycles = 3'h4;
                    end
                    default: ;
                endcase
            end
            default: begin
                // register and indirect columns share one layout except row D, where only lo[3] columns take three cycles
                case (hi)
                    4'h7, 4'h8, 4'hA: begin
                        byte_count = 2'h2;
                        base_cycles = 3'h2;
                    end
                    4'hB: begin
                        byte_count = 2'h3;
                        base_cycles = 3'h4;
                    end
                    4'hD: begin
                        if (lo[3]) begin
                            byte_count = 2'h2;
                            base_cycles = 3'h3;
                        end
                    end
                    default: ;
                endcase
            end
        endcase
    end

endmodule // opcode_length_decoder
`default_nettype wire

// >>> rtl/instruction_cycle_timing.sv
// machine cycle sequencer with opcode fetch pacing and stretched data strobes
`timescale 1ns/1ns
`default_nettype none
module instruction_cycle_timing
    import cycle_timing_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] opcode_in,
    input wire logic stretch_wr,
    input wire logic [2:0] stretch_wdata,
    output logic [3:0] phase,
    output logic [3:0] machine_cycle,
    output logic fetch,
    output logic instr_done,
    output logic rd_n,
    output logic wr_n,
    output logic [2:0] stretch_value
);

    phase_t phase_ff;
    phase_t nxt_phase;
    logic [3:0] mc_ff;
    logic [3:0] nxt_mc;
    logic [7:0] opcode_ff;
    logic [2:0] stretch_ff;
    logic [2:0] cur_stretch_ff;
    logic fetch_ff;
    logic done_ff;
    logic rd_n_ff;
    logic wr_n_ff;

    wire [1:0] byte_count;
    wire [2:0] base_cycles;
    wire is_xmove;
    wire is_write;

    opcode_length_decoder u_dec (
        .opcode(opcode_ff),
        .byte_count(byte_count),
        .base_cycles(base_cycles),
        .is_xmove(is_xmove),
        .is_write(is_write)
    );

    // move length is two plus stretch
    wire [3:0] total_cycles = is_xmove ? (XMOVE_BASE_CYCLES + {1'b0, cur_stretch_ff})
                                       : {1'b0, base_cycles};
    wire last_cycle = (mc_ff == (total_cycles - 4'h1));
    wire at_end = (phase_ff == phase_four) && last_cycle;
    wire new_instr = (nxt_phase == phase_one) && (nxt_mc == MCYCLE_RST);

    always_comb begin
        case (phase_ff)
            phase_one: nxt_phase = phase_two;
            phase_two: nxt_phase = phase_three;
            phase_three: nxt_phase = phase_four;
            phase_four: nxt_phase = phase_one;
            default: nxt_phase = phase_one;
        endcase
    end

    assign nxt_mc = (phase_ff != phase_four) ? mc_ff : (last_cycle ? MCYCLE_RST : mc_ff + 4'h1);

    wire nxt_fetch = (nxt_phase == phase_one) && (new_instr || (nxt_mc < {2'h0, byte_count}));
    wire nxt_done = (nxt_phase == phase_four) && (nxt_mc == (total_cycles - 4'h1));

    // strobe window over the next state; zero stretch keeps a two-clock pulse
    function automatic logic strobe_on(input logic [3:0] mc, input phase_t ph,
                                       input logic [2:0] s);
        logic [3:0] last_mc;
        last_mc = 4'h1 + {1'b0, s};
        if (s == 3'h0)
            strobe_on = (mc == 4'h1) && ((ph == phase_two) || (ph == phase_three));
        else
            strobe_on = ((mc == 4'h1) && ((ph == phase_three) || (ph == phase_four)))
                     || ((mc > 4'h1) && (mc < last_mc))
                     || ((mc == last_mc) && ((ph == phase_one) || (ph == phase_two)));
    endfunction

    wire nxt_strobe = is_xmove && !new_instr && strobe_on(nxt_mc, nxt_phase, cur_stretch_ff);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // parked at the end of a one-cycle no-op so the first edge starts a fetch
            phase_ff <= phase_four;
            mc_ff <= MCYCLE_RST;
            fetch_ff <= 1'b0;
            done_ff <= 1'b0;
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
        end else begin
            phase_ff <= nxt_phase;
            mc_ff <= nxt_mc;
            fetch_ff <= nxt_fetch;
            done_ff <= nxt_done && !new_instr;
            rd_n_ff <= !(nxt_strobe && !is_write);
            wr_n_ff <= !(nxt_strobe && is_write);
        end
    end

    // stretch field of the clock control register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stretch_ff <= STRETCH_RST;
            cur_stretch_ff <= STRETCH_RST;
        end else begin
            if (stretch_wr)
                stretch_ff <= stretch_wdata;
            if (at_end)
                cur_stretch_ff <= stretch_ff;
        end
    end

    // opcode caught on falling edge
    // the half-period lead gives the decoder time before phase four
    always_ff @(negedge clk) begin
        if (sys_rst)
            opcode_ff <= OPCODE_RST;
        else if ((phase_ff == phase_one) && (mc_ff == MCYCLE_RST))
            opcode_ff <= opcode_in;
    end

    assign phase = phase_ff;
    assign machine_cycle = mc_ff;
    assign fetch = fetch_ff;
    assign instr_done = done_ff;
    assign rd_n = rd_n_ff;
    assign wr_n = wr_n_ff;
    assign stretch_value = stretch_ff;

    // helper counters read only by the checks below
    logic [5:0] clk_cnt_ff;
    logic [5:0] strobe_cnt_ff;
    logic [1:0] fetch_cnt_ff;
    wire strobe_now = !(rd_n_ff && wr_n_ff);
    wire [5:0] exp_width = (cur_stretch_ff == 3'h0) ? 6'h02 : {1'b0, cur_stretch_ff, 2'h0};
    wire [5:0] exp_clocks = {total_cycles, 2'h0};
    wire is_compare_jump_not_equal = (opcode_ff >= COMPARE_JUMP_NOT_EQUAL_FIRST) && (opcode_ff <= COMPARE_JUMP_NOT_EQUAL_LAST);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clk_cnt_ff <= COUNT_RST;
            strobe_cnt_ff <= COUNT_RST;
            fetch_cnt_ff <= 2'h0;
        end else begin
            clk_cnt_ff <= new_instr ? COUNT_RST : clk_cnt_ff + 6'h01;
            strobe_cnt_ff <= strobe_now ? strobe_cnt_ff + 6'h01 : COUNT_RST;
            fetch_cnt_ff <= new_instr ? 2'h0 : fetch_cnt_ff + {1'b0, fetch_ff};
        end
    end

    chk_phase_order: assert property (@(posedge clk) disable iff (sys_rst)
        (phase_ff == phase_four) |=> (phase_ff == phase_one) ##1 (phase_ff == phase_two)
        ##1 (phase_ff == phase_three)) else $error("phase order broken");
    chk_negedge_latch: assert property (@(negedge clk) disable iff (sys_rst)
        ((phase_ff == phase_one) && (mc_ff == MCYCLE_RST)) |=> (opcode_ff == $past(opcode_in)))
        else $error("opcode not caught on falling edge");
    chk_fetch_once: assert property (@(posedge clk) disable iff (sys_rst)
        fetch_ff |-> (phase_ff == phase_one) ##1 !fetch_ff [*3])
        else $error("more than one fetch in a machine cycle");
    chk_fetch_count: assert property (@(posedge clk) disable iff (sys_rst)
        (done_ff && !is_xmove) |-> (fetch_cnt_ff == byte_count))
        else $error("fetch count differs from byte count");
    chk_fetch_first: assert property (@(posedge clk) disable iff (sys_rst)
        ((phase_ff == phase_one) && (mc_ff == MCYCLE_RST)) |-> fetch_ff)
        else $error("instruction started without a fetch");
    chk_done_fetch: assert property (@(posedge clk) disable iff (sys_rst)
        done_ff |=> (phase_ff == phase_one) && (mc_ff == MCYCLE_RST) && fetch_ff)
        else $error("no fetch after instruction end");
    chk_opcode_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (mc_ff != MCYCLE_RST) |-> $stable(opcode_ff))
        else $error("opcode changed inside an instruction");
    chk_decode_total: assert property (@(posedge clk) disable iff (sys_rst)
        (byte_count != 2'h0) && (base_cycles != 3'h0)) else $error("opcode left undecoded");
    chk_xmove_len: assert property (@(posedge clk) disable iff (sys_rst)
        (done_ff && is_xmove) |-> (clk_cnt_ff == 6'(exp_clocks - 6'h01))
        && (total_cycles >= 4'h2) && (total_cycles <= 4'h9))
        else $error("external move length wrong");
    // strobe checks read the registered pins, so they see exactly what the bus sees
    // strobe width
    chk_strobe_width: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(strobe_now) |-> (strobe_cnt_ff == exp_width)) else $error("strobe width wrong");
    chk_strobe_in_move: assert property (@(posedge clk) disable iff (sys_rst)
        strobe_now |-> is_xmove && (mc_ff != MCYCLE_RST))
        else $error("strobe outside the access cycles");
    chk_strobe_excl: assert property (@(posedge clk) disable iff (sys_rst)
        !(!rd_n_ff && !wr_n_ff)) else $error("read and write strobes together");
    chk_class_range: assert property (@(posedge clk) disable iff (sys_rst)
        (done_ff && !is_xmove) |-> (total_cycles >= 4'h1) && (total_cycles <= 4'h5)
        && (clk_cnt_ff == 6'(exp_clocks - 6'h01))) else $error("instruction class wrong");
    chk_mc_range: assert property (@(posedge clk) disable iff (sys_rst)
        (mc_ff < total_cycles)) else $error("machine cycle index out of range");
    chk_compare_jump_not_equal_clocks: assert property (@(posedge clk) disable iff (sys_rst)
        (done_ff && is_compare_jump_not_equal) |-> (clk_cnt_ff == (COMPARE_JUMP_NOT_EQUAL_CLOCKS - 6'h01))
        && (byte_count == COMPARE_JUMP_NOT_EQUAL_BYTES)) else $error("compare jump not sixteen clocks");
    chk_stretch_write: assert property (@(posedge clk) disable iff (sys_rst)
        stretch_wr |=> (stretch_ff == $past(stretch_wdata)))
        else $error("stretch write lost");
    chk_stretch_scope: assert property (@(posedge clk) disable iff (sys_rst)
        !is_xmove |-> ##1 (rd_n_ff && wr_n_ff) or (mc_ff == MCYCLE_RST))
        else $error("strobe outside external move");
    chk_stretch_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !at_end |=> $stable(cur_stretch_ff)) else $error("stretch changed inside an instruction");

    cov_xmove_read: cover property (@(posedge clk) disable iff (sys_rst) $fell(rd_n_ff));
    cov_xmove_write: cover property (@(posedge clk) disable iff (sys_rst) $fell(wr_n_ff));
    cov_compare_jump_not_equal_done: cover property (@(posedge clk) disable iff (sys_rst) done_ff && is_compare_jump_not_equal);
    cov_max_stretch: cover property (@(posedge clk) disable iff (sys_rst)
        done_ff && is_xmove && (cur_stretch_ff == 3'h7));
    cov_zero_stretch: cover property (@(posedge clk) disable iff (sys_rst)
        done_ff && is_xmove && (cur_stretch_ff == 3'h0));

endmodule // instruction_cycle_timing
`default_nettype wire

// >>> verif/ext_bus_model.sv
// external data bus side: measures read and write strobe widths
`timescale 1ns/1ns
`default_nettype none
module ext_bus_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic rd_n,
    input wire logic wr_n,
    output logic [5:0] rd_width,
    output logic [5:0] wr_width,
    output logic overlap
);
    logic [5:0] rd_cnt_ff;
    logic [5:0] wr_cnt_ff;
    logic [5:0] rd_last_ff;
    logic [5:0] wr_last_ff;

    // a strobe that has just risen reports its count at once: a pulse that ends on the
    // edge opening the last phase is then visible while that instruction is checked
    assign rd_width = (rd_n && (rd_cnt_ff != 6'h00)) ? rd_cnt_ff : rd_last_ff;
    assign wr_width = (wr_n && (wr_cnt_ff != 6'h00)) ? wr_cnt_ff : wr_last_ff;

    // width is reported only once the strobe returns high, so a stuck strobe never reports
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_cnt_ff <= 6'h00;
            wr_cnt_ff <= 6'h00;
            rd_last_ff <= 6'h00;
            wr_last_ff <= 6'h00;
            overlap <= 1'b0;
        end else begin
            rd_cnt_ff <= rd_n ? 6'h00 : rd_cnt_ff + 6'h01;
            wr_cnt_ff <= wr_n ? 6'h00 : wr_cnt_ff + 6'h01;
            if (rd_n && rd_cnt_ff != 6'h00) begin
                rd_last_ff <= rd_cnt_ff;
            end
            if (wr_n && wr_cnt_ff != 6'h00) begin
                wr_last_ff <= wr_cnt_ff;
            end
            if (!rd_n && !wr_n) begin
                overlap <= 1'b1;
            end
        end
    end
endmodule // ext_bus_model
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the instruction cycle timing block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    import cycle_timing_pkg::*;
    logic clk, sys_rst, stretch_wr, fetch, instr_done, rd_n, wr_n, overlap;
    logic [7:0] opcode_in;
    logic [2:0] stretch_wdata, stretch_value;
    logic [3:0] phase, machine_cycle, mc_done;
    logic [5:0] rd_width, wr_width;
    int err_count, checked, n_clk, n_fetch, n_rd, n_wr, s_cur, k;
    logic [7:0] xmove_ops [6] = '{8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3};
    logic [7:0] plain_ops [8] = '{8'h00, 8'hC8, 8'hD8, 8'hD5, 8'h80, 8'h12, 8'h10, 8'hC0};

    instruction_cycle_timing DUT (.clk(clk), .sys_rst(sys_rst), .opcode_in(opcode_in),
        .stretch_wr(stretch_wr), .stretch_wdata(stretch_wdata), .phase(phase),
        .machine_cycle(machine_cycle), .fetch(fetch), .instr_done(instr_done),
        .rd_n(rd_n), .wr_n(wr_n), .stretch_value(stretch_value));
    ext_bus_model mem (.clk(clk), .sys_rst(sys_rst), .rd_n(rd_n), .wr_n(wr_n),
        .rd_width(rd_width), .wr_width(wr_width), .overlap(overlap));

    function automatic int op_bytes(input logic [7:0] o);
        case (o)
            8'hD5, 8'h12, 8'h10: return 3;
            8'hD8, 8'h80, 8'hC0: return 2;
            default: return (o >= COMPARE_JUMP_NOT_EQUAL_FIRST && o <= COMPARE_JUMP_NOT_EQUAL_LAST) ? 3 : 1;
        endcase
    endfunction

    function automatic int op_cycles(input logic [7:0] o, input int s);
        case (o)
            8'hD5, 8'h12, 8'h10: return 4;
            8'hD8, 8'h80: return 3;
            8'hC0: return 2;
            8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: return 2 + s;
            default: return (o >= COMPARE_JUMP_NOT_EQUAL_FIRST && o <= COMPARE_JUMP_NOT_EQUAL_LAST) ? 4 : 1;
        endcase
    endfunction

    function automatic int strobe_clocks(input int s);
        return (s == 0) ? 2 : 4 * s;
    endfunction

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    // check_instr calls it in the closing phase_four, so the opcode is steady before the next fetch
    task automatic run(input logic [7:0] o);
        opcode_in = o;
        n_clk = 0;
        n_fetch = 0;
        n_rd = 0;
        n_wr = 0;
        do begin
            step();
            n_clk++;
            n_fetch += (fetch === 1'b1);
            n_rd += (rd_n === 1'b0);
            n_wr += (wr_n === 1'b0);
        end while (instr_done !== 1'b1 && n_clk < 200);
        mc_done = machine_cycle;
    endtask

    task automatic check_instr(input logic [7:0] o, input int s, input logic mv);
        int cyc;
        cyc = op_cycles(o, s);
        run(o);
        `CHK("clocks", 4 * cyc, n_clk)
        `CHK("fetches", op_bytes(o), n_fetch)
        `CHK("last machine cycle", 4'(cyc - 1), mc_done)
        if (mv) begin
            `CHK("strobe width", 6'(strobe_clocks(s)), o[4] ? wr_width : rd_width)
            `CHK("strobe clocks", strobe_clocks(s), o[4] ? n_wr : n_rd)
            `CHK("idle strobe clocks", 0, o[4] ? n_rd : n_wr)
        end else begin
            `CHK("strobes outside move", 0, n_rd + n_wr)
        end
    endtask

    // new value applies from the instruction after the running one
    task automatic set_stretch(input logic [2:0] v);
        opcode_in = 8'h00;
        stretch_wr = 1'b1;
        stretch_wdata = v;
        step();
        stretch_wr = 1'b0;
        stretch_wdata = 3'($urandom_range(7));
        `CHK("stretch value", v, stretch_value)
        run(8'h00);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end

    initial begin
        #200000;
        err_count++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        end_sim();
    end

    initial begin
        err_count = 0;
        checked = 0;
        sys_rst = 1'b1;
        opcode_in = 8'h00;
        stretch_wr = 1'b0;
        stretch_wdata = 3'h0;
        void'($urandom(63));
        repeat (10) @(posedge clk);
        #1;
        `CHK("reset phase", phase_four, phase)
        `CHK("reset stretch", STRETCH_RST, stretch_value)
        `CHK("reset rd_n", 1'b1, rd_n)
        sys_rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            step();
            `CHK("walk phase", 4'h1 << i, phase)
            `CHK("walk fetch", i == 0, fetch)
            `CHK("walk done", i == 3, instr_done)
        end
        $display("test reset_walk done");
        check_instr(8'hE0, 1, 1'b1);
        `CHK("default move cycles", 3, n_clk / 4)
        $display("test default_stretch done");
        // every stretch value, every move opcode
        for (int s = 0; s < 8; s++) begin
            set_stretch(3'(s));
            check_instr(xmove_ops[s % 6], s, 1'b1);
            `CHK("move cycles", 2 + s, n_clk / 4)
            check_instr(8'hB4 + 8'(s), s, 1'b0);
            `CHK("compare_jump_not_equal under stretch", 16, n_clk)
        end
        $display("test stretch_sweep done");
        for (int o = 8'hB4; o <= 8'hBF; o++) begin
            check_instr(8'(o), 7, 1'b0);
            `CHK("compare_jump_not_equal clocks", 16, n_clk)
        end
        $display("test compare_jump_not_equal_group done");
        s_cur = $urandom_range(7);
        set_stretch(3'(s_cur));
        repeat (40) begin
            k = $urandom_range(13);
            if (k < 8) begin
                check_instr(plain_ops[k], s_cur, 1'b0);
            end else begin
                check_instr(xmove_ops[k - 8], s_cur, 1'b1);
            end
        end
        `CHK("strobe overlap", 1'b0, overlap)
        $display("test random_mix done");
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
